// ### rtl/fce_pkg.sv
// constants shared by the cascade-able fifo stage
package fce_pkg;
  // ==========================================================
  // data path
  localparam int unsigned DATA_W      = 36;  // word width of one device
  localparam int unsigned FIFO_DEPTH  = 16;  // words held in the core
  localparam int unsigned PTR_W       = 4;   // index width for depth
  // ==========================================================
  // ripple timing, counted in clock cycles of the single clock
  localparam int unsigned CLK_PERIOD_NS  = 8;  // 125 mhz
  localparam int unsigned RIPPLE_XFER    = 4;  // per extra stage, down
  localparam int unsigned RIPPLE_READ    = 3;  // last stage, down
  localparam int unsigned BUBBLE_XFER    = 3;  // per extra stage, up
  localparam int unsigned BUBBLE_WRITE   = 2;  // first stage, up
  // ==========================================================
  // reset values of the active-low flags (empty, not ready)
  localparam logic RST_OUT_READY_N = 1'b1;
  localparam logic RST_IN_READY_N  = 1'b1;
  localparam logic RST_EMPTY_N     = 1'b0;
  localparam logic RST_FULL_N      = 1'b1;
  // ==========================================================
  // mode latched during master reset
  typedef enum logic {
    FCE_STANDARD_MODE = 1'b0,
    FCE_FALLTHRU_MODE = 1'b1
  } fce_mode_type;
  // output stage state, gray along empty -> loading -> holding
  typedef enum logic [1:0] {
    FCE_OUT_EMPTY = 2'b00,
    FCE_OUT_LOAD  = 2'b01,
    FCE_OUT_HOLD  = 2'b11
  } fce_out_type;
endpackage : fce_pkg

// ### rtl/fce_fifo_core.sv
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module fce_fifo_core #(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  // ==========================================================
  // storage and pointers
  logic [WIDTH-1:0] mem_reg [DEPTH];   // word storage
  logic [AW-1:0]    wr_ptr_reg;        // next write slot
  logic [AW-1:0]    rd_ptr_reg;        // oldest word
  logic [AW:0]      count_reg;         // words held
  wire              push;              // accepted write
  wire              pop;               // accepted read

  // room while fewer than depth words are held
  assign in_ready  = (count_reg < (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // write side, storage only, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and count; depth is a power of two so wrap is free
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop) count_reg <= count_reg + 1'b1;
      else if (pop && !push) count_reg <= count_reg - 1'b1;
    end
  end
endmodule : fce_fifo_core

// ### rtl/fce_stage.sv
// one cascade-able fall-through fifo stage with active-low flags
//
// Overview of operation
// - ready flags may differ one cycle
// - depth chaining only in fall-through mode
// - first word falls through without read
// - output-ready low when word at outputs
// - empty chain latency: stage output three cycles
// - only first word pays ripple latency
// - freed slot raises input-ready low upstream
// - full chain bubble-up: input-ready one cycle
// - fall-through load drives output-ready low
`timescale 1ns/10ps
module fce_stage (
  input  wire logic                         CLK,
  input  wire logic                         RST,
  input  wire logic                         CE,
  input  wire logic                         MODE_SEL,
  input  wire logic                         WRITE_EN_N,
  input  wire logic [fce_pkg::DATA_W-1:0]   WR_DATA,
  input  wire logic                         READ_EN_N,
  output logic      [fce_pkg::DATA_W-1:0]   RD_DATA,
  output logic                              INPUT_READY_N,
  output logic                              OUTPUT_READY_N,
  output logic                              FULL_INDICATION_N,
  output logic                              EMPTY_FLAG_N
);
  // ==========================================================
  // mode capture, taken by a clocked process while reset is held
  fce_pkg::fce_mode_type mode_reg;          // latched mode
  wire fallthru = (mode_reg == fce_pkg::FCE_FALLTHRU_MODE);

  // mode sampled on every reset cycle, frozen afterwards
  always_ff @(posedge CLK) begin
    if (RST) begin
      mode_reg <= fce_pkg::fce_mode_type'(MODE_SEL);
    end
  end

  // ==========================================================
  // write side: one register stage in front of the core keeps
  // the write path short, at the cost of one edge of latency
  logic                        wr_take_reg;   // registered write
  logic [fce_pkg::DATA_W-1:0]  wr_data_reg;   // registered word
  wire                         core_in_ready; // core has room
  wire                         core_out_valid;
  wire [fce_pkg::DATA_W-1:0]   core_out_data;
  wire                         core_pop;      // core to output reg
  wire                         wr_accept;     // write taken this edge

  // write only counts while input-ready is shown low
  assign wr_accept = !WRITE_EN_N && !INPUT_READY_N;

  // input pipeline register
  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_take_reg <= 1'b0;
    end else if (CE) begin
      wr_take_reg <= wr_accept;
      if (wr_accept) wr_data_reg <= WR_DATA;
    end
  end

  // ==========================================================
  // occupancy of the write register and the core together; the
  // ready flag is judged on this sum, so a word waiting in the
  // write register always finds a free core slot one edge later
  logic [fce_pkg::PTR_W:0] held_reg;   // words in write reg and core
  logic [fce_pkg::PTR_W:0] held_next;  // words held after this edge

  // one word in, one word out to the output register, or both
  always_comb begin
    held_next = held_reg;
    if (wr_accept && !core_pop) begin
      held_next = held_reg + 1'b1;  // write only
    end else if (core_pop && !wr_accept) begin
      held_next = held_reg - 1'b1;  // load only
    end
  end

  // occupancy register, frozen with the clock enable
  always_ff @(posedge CLK) begin
    if (RST) begin
      held_reg <= '0;
    end else if (CE) begin
      held_reg <= held_next;
    end
  end

  // ==========================================================
  // buffer between write register and output register
  fce_fifo_core #(
    .WIDTH (fce_pkg::DATA_W),
    .DEPTH (fce_pkg::FIFO_DEPTH),
    .AW    (fce_pkg::PTR_W)
  ) u_core (
    .clk       (CLK),
    .rst       (RST),
    .ce        (CE),
    .in_valid  (wr_take_reg),
    .in_ready  (core_in_ready),
    .in_data   (wr_data_reg),
    .out_valid (core_out_valid),
    .out_ready (core_pop),
    .out_data  (core_out_data)
  );

  // ==========================================================
  // output side
  fce_pkg::fce_out_type out_state_reg, out_state_next; // out reg state
  logic                  rd_take;                     // read accepted
  logic [fce_pkg::DATA_W-1:0] rd_data_reg;            // output word

  // a read in fall-through mode consumes the shown word; in
  // standard mode a read pulls the next word (word loaded on read)
  assign rd_take  = !READ_EN_N && (out_state_reg == fce_pkg::FCE_OUT_HOLD);
  // fall-through refills the output register when empty or on a read; standard only on a read request
  assign core_pop = core_out_valid &&
                    (fallthru ? (out_state_reg == fce_pkg::FCE_OUT_EMPTY ||
                                 rd_take)
                              : !READ_EN_N);

  // next state of the output register
  always_comb begin
    out_state_next = out_state_reg;
    case (out_state_reg)
      fce_pkg::FCE_OUT_EMPTY: begin
        if (core_pop) out_state_next = fce_pkg::FCE_OUT_LOAD;
      end
      fce_pkg::FCE_OUT_LOAD: begin
        out_state_next = fce_pkg::FCE_OUT_HOLD; // word now visible
      end
      fce_pkg::FCE_OUT_HOLD: begin
        // later words skip the load stage: no extra latency
        if (rd_take && !core_pop) out_state_next = fce_pkg::FCE_OUT_EMPTY;
      end
      default: out_state_next = fce_pkg::FCE_OUT_EMPTY;
    endcase
  end

  // output word and state registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      out_state_reg <= fce_pkg::FCE_OUT_EMPTY;
      rd_data_reg   <= '0;
    end else if (CE) begin
      out_state_reg <= out_state_next;
      if (core_pop) rd_data_reg <= core_out_data;
    end
  end
  assign RD_DATA = rd_data_reg;

  // ==========================================================
  // flags, each straight from a flip-flop
  logic out_ready_n_reg;   // low while a word is at the outputs
  logic in_ready_n_reg;    // low while room remains
  logic empty_n_reg;       // high while a word is at the outputs
  logic full_n_reg;        // low while no room remains
  // word arrives at outputs one edge after the load state
  wire  out_ready_n_next =
    !(out_state_next == fce_pkg::FCE_OUT_HOLD);
  // room judged on what is held after this edge, so a write taken
  // on the next edge can never meet a full core
  wire  in_ready_n_next  =
    !(held_next < (fce_pkg::PTR_W+1)'(fce_pkg::FIFO_DEPTH));

  // flag registers; mode decides which pair is meaningful
  always_ff @(posedge CLK) begin
    if (RST) begin
      out_ready_n_reg <= fce_pkg::RST_OUT_READY_N;
      in_ready_n_reg  <= fce_pkg::RST_IN_READY_N;
      empty_n_reg     <= fce_pkg::RST_EMPTY_N;
      full_n_reg      <= fce_pkg::RST_FULL_N;
    end else if (CE) begin
      out_ready_n_reg <= out_ready_n_next;
      in_ready_n_reg  <= in_ready_n_next;
      empty_n_reg     <= !out_ready_n_next;
      full_n_reg      <= !in_ready_n_next;
    end
  end
  // fall-through uses the ready pair, standard the empty/full pair;
  // each pair has flops of its own so every output leaves a
  // register, at the cost of two flops; a chain uses the ready pair
  assign OUTPUT_READY_N    = out_ready_n_reg;
  assign INPUT_READY_N     = in_ready_n_reg;
  assign EMPTY_FLAG_N      = empty_n_reg;
  assign FULL_INDICATION_N = full_n_reg;

  // ==========================================================
  // checks
  // a word enters the core while the output register waits
  sequence s_first_write;
    $rose(wr_take_reg) && (out_state_reg == fce_pkg::FCE_OUT_EMPTY);
  endsequence

  // first word shown within three edges of entering the core
  a_fall_through: assert property (
    @(posedge CLK) disable iff (RST || !CE)
    (s_first_write and (fallthru && !core_out_valid))
      |-> ##[1:3] !OUTPUT_READY_N)
    else $error("first word did not fall through");
  a_ready_word: assert property (
    @(posedge CLK) disable iff (RST)
    !OUTPUT_READY_N |-> out_state_reg == fce_pkg::FCE_OUT_HOLD)
    else $error("output ready low without a word");
  a_no_read_ovr: assert property (
    @(posedge CLK) disable iff (RST)
    (OUTPUT_READY_N && fallthru) |-> !rd_take)
    else $error("read taken with no word shown");
  a_room_ready: assert property (
    @(posedge CLK) disable iff (RST)
    !INPUT_READY_N |-> u_core.count_reg < 5'(fce_pkg::FIFO_DEPTH))
    else $error("input ready low while core full");
  // a word in the write register must never be dropped
  a_wr_drain: assert property (
    @(posedge CLK) disable iff (RST)
    wr_take_reg |-> core_in_ready)
    else $error("write register met a full core");
  a_mode_hold: assert property (
    @(posedge CLK) disable iff (RST)
    $stable(mode_reg))
    else $error("mode changed outside reset");
  a_empty_pair: assert property (
    @(posedge CLK) disable iff (RST)
    EMPTY_FLAG_N != OUTPUT_READY_N)
    else $error("empty and ready flags disagree");
  a_full_pair: assert property (
    @(posedge CLK) disable iff (RST)
    !FULL_INDICATION_N |-> INPUT_READY_N)
    else $error("full shown while input ready");
  a_bubble_up: assert property (
    @(posedge CLK) disable iff (RST || !CE)
    ($rose(core_in_ready) && !wr_accept) |=> !INPUT_READY_N)
    else $error("freed slot not shown");
  a_freeze_ce: assert property (
    @(posedge CLK) disable iff (RST)
    !CE |=> $stable(out_state_reg))
    else $error("state moved while disabled");
endmodule : fce_stage

// ### sim/fce_consumer.sv
// consumer model reading the stage's fall-through output
`timescale 1ns/10ps
module fce_consumer (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       enable,
  input  wire logic                       stall,
  input  wire logic                       out_ready_n,
  input  wire logic [fce_pkg::DATA_W-1:0] rd_data,
  output logic                            read_en_n = 1'b1,
  output logic                            got = 1'b0,
  output logic      [fce_pkg::DATA_W-1:0] got_data = '0
);
  // ==========================================================
  // request handshake
  logic tick_reg = 1'b0;  // stall phase, every other cycle
  wire  taken = !read_en_n && !out_ready_n;  // read accepted here
  // a request is held until taken; disable aborts it on purpose
  always @(posedge clk) begin
    tick_reg <= !tick_reg;
    got      <= taken && !rst;
    if (taken)
      got_data <= rd_data;
    if (rst || taken || read_en_n || !enable)
      read_en_n <= #1 !(enable && !rst && !(stall && tick_reg));
  end
endmodule : fce_consumer

// ### sim/fce_stage_tb.sv
// self-checking bench for one fall-through stage
`timescale 1ns/10ps
module fce_stage_tb;
  // ==========================================================
  // stimulus and observation
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        MODE_SEL = 1'b1;  // fall-through latched in reset
  logic        WRITE_EN_N = 1'b1;
  logic [35:0] WR_DATA = '0;
  logic [35:0] RD_DATA;
  logic        READ_EN_N, INPUT_READY_N, OUTPUT_READY_N;
  logic        FULL_INDICATION_N, EMPTY_FLAG_N, got;
  logic [35:0] got_data;
  logic        cons_en = 1'b0;
  logic        cons_stall = 1'b0;
  logic        CE = 1'b1;  // clock enable, dropped in one test
  int          fail_count = 0;
  int          tests_run = 0;
  int          cycle_count = 0;
  int          run_len = 0;  // consecutive receipts
  int          run_peak = 0;
  logic [35:0] exp_q[$];  // words in flight, oldest first
  always #4 CLK = ~CLK;
  // one stage alone on one clock: its own controls, data and flags
  fce_stage dut (.CLK(CLK), .RST(RST), .CE(CE), .MODE_SEL(MODE_SEL),
    .WRITE_EN_N(WRITE_EN_N), .WR_DATA(WR_DATA), .READ_EN_N(READ_EN_N),
    .RD_DATA(RD_DATA), .INPUT_READY_N(INPUT_READY_N),
    .OUTPUT_READY_N(OUTPUT_READY_N),
    .FULL_INDICATION_N(FULL_INDICATION_N), .EMPTY_FLAG_N(EMPTY_FLAG_N));
  fce_consumer cons (.clk(CLK), .rst(RST), .enable(cons_en),
    .stall(cons_stall), .out_ready_n(OUTPUT_READY_N), .rd_data(RD_DATA),
    .read_en_n(READ_EN_N), .got(got), .got_data(got_data));
  // ==========================================================
  // helpers
  function automatic logic [35:0] wd(input int i);
    return {28'h00c3a5f, i[7:0]};
  endfunction : wd
  task automatic step();
    @(posedge CLK);
    #1;
  endtask : step
  task automatic check1(input logic g, input logic e, input string m);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : check1
  task automatic checkw(input logic [35:0] g, input logic [35:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t word %h not %h", $time, g, e);
    end
  endtask : checkw
  // one write, held until the stage has room
  task automatic push(input int i, input bit last);
    WRITE_EN_N = 1'b0;
    WR_DATA = wd(i);
    while (INPUT_READY_N !== 1'b0)
      step();
    step();
    exp_q.push_back(wd(i));
    if (last) begin
      WRITE_EN_N = 1'b1;
      WR_DATA = ~WR_DATA;  // released bus shows no stale word
    end
  endtask : push
  task automatic summarize();
    $display("counts: %0d compares %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  // ==========================================================
  // receipt order, gap tracking and hang guard
  always @(posedge CLK) begin
    cycle_count++;
    if (cycle_count == 2000) begin
      fail_count++;
      summarize();
    end
    run_len = (got === 1'b1) ? run_len + 1 : 0;
    if (run_len > run_peak)
      run_peak = run_len;
    if (got === 1'b1)
      checkw(got_data, exp_q.pop_front());
  end
  // ==========================================================
  // scenarios
  task automatic t_reset();
    check1(OUTPUT_READY_N, 1'b1, "or in reset");
    check1(INPUT_READY_N, 1'b1, "ir in reset");
    check1(EMPTY_FLAG_N, 1'b0, "empty in reset");
    check1(RD_DATA === 36'h000000000, 1'b1, "data in reset");
    step();
    step();
    check1(INPUT_READY_N, 1'b0, "room after reset");
    check1(FULL_INDICATION_N, 1'b1, "full inverse");
    $display("test reset done");
  endtask : t_reset
  task automatic t_first();
    push(1, 1);
    step();
    step();
    check1(OUTPUT_READY_N, 1'b1, "early word");
    step();
    check1(OUTPUT_READY_N, 1'b0, "no fall-through");
    check1(EMPTY_FLAG_N, 1'b1, "empty inverse");
    checkw(RD_DATA, wd(1));
    repeat (3) step();
    check1(OUTPUT_READY_N, 1'b0, "word not held");
    cons_en = 1'b1;
    repeat (4) step();
    check1(OUTPUT_READY_N, 1'b1, "not empty after read");
    $display("test first word done");
  endtask : t_first
  task automatic t_stream();
    run_peak = 0;
    for (int i = 2; i < 6; i++)
      push(i, i == 5);
    repeat (8) step();
    check1(run_peak == 4, 1'b1, "gap after first word");
    $display("test stream done");
  endtask : t_stream
  task automatic t_fill();
    int n;
    n = 0;
    cons_en = 1'b0;
    step();
    WRITE_EN_N = 1'b0;
    for (int k = 0; k < 40 && INPUT_READY_N === 1'b0; k++) begin
      WR_DATA = wd(10 + n);
      step();
      exp_q.push_back(wd(10 + n));
      n++;
    end
    repeat (3) step();  // refused writes must leave no trace
    check1(n >= 16 && n <= 18, 1'b1, "depth");
    check1(FULL_INDICATION_N, 1'b0, "full flag");
    WRITE_EN_N = 1'b1;
    WR_DATA = ~WR_DATA;
    cons_en = 1'b1;
    for (int k = 0; k < 10 && got !== 1'b1; k++)
      step();
    cons_en = 1'b0;
    step();
    check1(INPUT_READY_N, 1'b0, "bubble up late");
    cons_stall = 1'b1;
    cons_en = 1'b1;
    repeat (60) step();
    check1(EMPTY_FLAG_N, 1'b0, "not drained");
    check1(exp_q.size() == 0, 1'b1, "words lost");
    $display("test fill and drain done");
  endtask : t_fill
  task automatic t_freeze();
    cons_en = 1'b0;
    cons_stall = 1'b0;
    repeat (2) step();
    CE = 1'b0;
    WRITE_EN_N = 1'b0;
    WR_DATA = wd(40);
    repeat (4) step();
    check1(OUTPUT_READY_N, 1'b1, "moved while frozen");
    CE = 1'b1;
    step();
    exp_q.push_back(wd(40));
    WRITE_EN_N = 1'b1;
    repeat (3) step();
    check1(OUTPUT_READY_N, 1'b0, "no word after thaw");
    cons_en = 1'b1;
    repeat (4) step();
    check1(exp_q.size() == 0, 1'b1, "frozen word lost");
    $display("test clock enable done");
  endtask : t_freeze
  task automatic t_standard();
    cons_en = 1'b0;
    MODE_SEL = 1'b0;  // standard mode latched in this reset
    RST = 1'b1;
    repeat (2) step();
    RST = 1'b0;
    repeat (2) step();
    check1(OUTPUT_READY_N, 1'b1, "word after reset");
    WRITE_EN_N = 1'b0;
    WR_DATA = wd(50);
    step();
    WRITE_EN_N = 1'b1;
    repeat (5) step();
    check1(OUTPUT_READY_N, 1'b1, "fell through in standard");
    exp_q.push_back(wd(50));
    cons_en = 1'b1;
    repeat (6) step();
    check1(exp_q.size() == 0, 1'b1, "standard read lost");
    check1(EMPTY_FLAG_N, 1'b0, "standard not empty");
    $display("test standard mode done");
  endtask : t_standard
  initial begin
    repeat (12) @(posedge CLK);
    #1;
    RST = 1'b0;
    t_reset();
    t_first();
    t_stream();
    t_fill();
    t_freeze();
    t_standard();
    summarize();
  end
endmodule : fce_stage_tb
